// ### rtl/sdw_pkg.sv
// Constants for the write-tail, precharge and self refresh sequencer.
// Assumes a single 100 MHz clock domain and synchronous pin inputs.
package sdw_pkg;

	// ****************************************************************
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	// ****************************************************************
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_RD    = 4'h5;
	localparam logic [3:0] CMD_WR    = 4'h4;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_ZQ    = 4'h6;

	// ****************************************************************
	// Fields and register layout
	// ****************************************************************
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam int         ADDR_AP   = 10;
	localparam int         ADDR_BL   = 12;

	localparam logic [3:0] REG_CFG    = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_BANKS  = 4'h2;
	localparam logic [3:0] REG_REFCNT = 4'h3;

	localparam logic [15:0] CFG_RESET = 16'h0005;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS  = 10000;
	localparam int TREF_SR_PS     = 5000000;
	localparam int TREF_SR_CYC    = TREF_SR_PS / CLK_PERIOD_PS;
	localparam int BURST8_BEATS   = 4;
	localparam int BURST4_BEATS   = 2;

	typedef enum logic [1:0] {
		SDW_IDLE = 2'b00,
		SDW_SR   = 2'b01,
		SDW_XS   = 2'b11
	} sdw_state_e;

endpackage : sdw_pkg

// ### rtl/sdw_core.sv
// Device-side sequencer: write burst tail, precharge decode, self refresh.
// Assumes the controller's command pins are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module sdw_core #(
	parameter int TXS_CYC    = 27,
	parameter int TXSDLL_CYC = 512,
	parameter int TREF_CYC   = sdw_pkg::TREF_SR_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Memory command pins
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  bank_addr,
	input  wire logic [15:0] addr,
	// Write data path
	input  wire logic [7:0]  wr_data,
	output logic [7:0]       wr_data_out,
	output logic             wr_data_valid,
	output logic             wr_burst_last,
	// Device state
	output logic             dll_enable,
	output logic             dll_reset,
	output logic             self_refresh,
	output logic             refresh_pulse,
	output logic             exit_busy,
	output logic [7:0]       bank_open,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata
);

	// ****************************************************************
	// Command decode
	// ****************************************************************
	logic [15:0] cfg;
	sdw_pkg::sdw_state_e state;
	sdw_pkg::sdw_state_e next_state;
	wire  [3:0]  cmd      = {cs_n, ras_n, cas_n, we_n};
	wire         in_sr    = (state == sdw_pkg::SDW_SR);
	// Pins other than CKE are masked while in self refresh
	wire         live     = cke && !in_sr;
	wire         is_wr    = live && cmd == sdw_pkg::CMD_WR;
	wire         is_act   = live && cmd == sdw_pkg::CMD_ACT;
	wire         is_pre   = live && cmd == sdw_pkg::CMD_PRE;
	// Re-entry is legal once the tXS part of the exit window is over
	wire         sr_ready = (state == sdw_pkg::SDW_IDLE)
		|| (state == sdw_pkg::SDW_XS && !exit_busy);
	wire         sr_entry = sr_ready && !cke
		&& cmd == sdw_pkg::CMD_REF;
	wire  [1:0]  bl_mode  = cfg[1:0];
	wire  [4:0]  wlat     = {2'h0, cfg[4:2]} + {1'b0, cfg[8:5]};
	// Chop-4 when fixed, or on the fly with A12 low
	wire         chop4    = (bl_mode == sdw_pkg::BL_FIXED4)
		|| (bl_mode == sdw_pkg::BL_OTF
		&& !addr[sdw_pkg::ADDR_BL]);
	wire  [2:0]  beats    = chop4 ? 3'(sdw_pkg::BURST4_BEATS)
		: 3'(sdw_pkg::BURST8_BEATS);

	// ****************************************************************
	// Bank state
	// ****************************************************************
	logic [7:0] next_bank_open;
	wire  [7:0] pre_mask = addr[sdw_pkg::ADDR_AP] ? 8'hff
		: 8'(8'h01 << bank_addr);
	wire  [7:0] act_mask = 8'(8'h01 << bank_addr);
	always_comb begin
		next_bank_open = bank_open;
		if (is_pre)
			next_bank_open = bank_open & ~pre_mask;
		if (is_act)
			next_bank_open = bank_open | act_mask;
	end
	always_ff @(posedge core_clk) begin
		if (rst)
			bank_open <= 8'h00;
		else
			bank_open <= next_bank_open;
	end

	// ****************************************************************
	// Write burst: latency then beats, one capture per clock
	// ****************************************************************
	// Strobe edges are modelled as clock cycles; DDR halves are wr_data
	logic [4:0] wl_cnt;
	logic       wl_run;
	logic [2:0] beat_left;
	logic [2:0] pend_beats;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wl_cnt     <= 5'h0;
			wl_run     <= 1'b0;
			pend_beats <= 3'h0;
		end else if (is_wr) begin
			wl_cnt     <= wlat;
			wl_run     <= 1'b1;
			pend_beats <= beats;
		end else if (wl_run) begin
			wl_cnt <= wl_cnt - 5'h1;
			if (wl_cnt <= 5'h1)
				wl_run <= 1'b0;
		end
	end
	wire data_start = wl_run && wl_cnt <= 5'h1;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			beat_left     <= 3'h0;
			wr_data_valid <= 1'b0;
			wr_burst_last <= 1'b0;
			wr_data_out   <= 8'h00;
		end else begin
			wr_data_valid <= data_start || beat_left > 3'h1;
			wr_burst_last <= (data_start && pend_beats == 3'h1)
				|| (!data_start && beat_left == 3'h2);
			wr_data_out   <= wr_data;
			if (data_start)
				beat_left <= pend_beats;
			else if (beat_left != 3'h0)
				beat_left <= beat_left - 3'h1;
		end
	end

	// ****************************************************************
	// Self refresh state machine
	// ****************************************************************
	logic [15:0] xs_cnt;
	logic [23:0] ref_cnt;
	logic [15:0] ref_total;
	wire         exit_edge = in_sr && cke;
	always_comb begin
		next_state = state;
		case (state)
			sdw_pkg::SDW_IDLE: if (sr_entry) next_state = sdw_pkg::SDW_SR;
			sdw_pkg::SDW_SR:   if (cke) next_state = sdw_pkg::SDW_XS;
			sdw_pkg::SDW_XS:
				if (sr_entry) next_state = sdw_pkg::SDW_SR;
				else if (xs_cnt == 16'h0) next_state = sdw_pkg::SDW_IDLE;
			default:           next_state = sdw_pkg::SDW_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst)
			state <= sdw_pkg::SDW_IDLE;
		else
			state <= next_state;
	end
	// Exit window covers the longer DLL relock interval
	always_ff @(posedge core_clk) begin
		if (rst)
			xs_cnt <= 16'h0;
		else if (exit_edge)
			xs_cnt <= 16'(TXSDLL_CYC - 1);
		else if (xs_cnt != 16'h0)
			xs_cnt <= xs_cnt - 16'h1;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dll_enable <= 1'b1;
			dll_reset  <= 1'b0;
		end else begin
			dll_reset <= exit_edge;
			if (sr_entry)
				dll_enable <= 1'b0;
			else if (exit_edge)
				dll_enable <= 1'b1;
		end
	end
	// Internal refresh fires on entry, then every TREF_CYC
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ref_cnt       <= 24'h0;
			refresh_pulse <= 1'b0;
			ref_total     <= 16'h0;
		end else begin
			refresh_pulse <= 1'b0;
			if (sr_entry) begin
				ref_cnt       <= 24'(TREF_CYC - 1);
				refresh_pulse <= 1'b1;
				ref_total     <= ref_total + 16'h1;
			end else if (in_sr && !cke) begin
				if (ref_cnt == 24'h0) begin
					ref_cnt       <= 24'(TREF_CYC - 1);
					refresh_pulse <= 1'b1;
					ref_total     <= ref_total + 16'h1;
				end else
					ref_cnt <= ref_cnt - 24'h1;
			end
		end
	end
	assign self_refresh = in_sr;
	assign exit_busy    = (state == sdw_pkg::SDW_XS)
		&& xs_cnt >= 16'(TXSDLL_CYC - TXS_CYC);

	// ****************************************************************
	// Register port
	// ****************************************************************
	wire         cfg_hit = reg_wr && reg_addr == sdw_pkg::REG_CFG;
	wire  [15:0] status  = {11'h0, chop4, dll_enable, exit_busy, state};
	logic [15:0] next_rdata;
	always_comb begin
		case (reg_addr)
			sdw_pkg::REG_CFG:    next_rdata = cfg;
			sdw_pkg::REG_STATUS: next_rdata = status;
			sdw_pkg::REG_BANKS:  next_rdata = {8'h00, bank_open};
			sdw_pkg::REG_REFCNT: next_rdata = ref_total;
			default:             next_rdata = 16'h0000;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg       <= sdw_pkg::CFG_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			if (cfg_hit)
				cfg <= reg_wdata;
			reg_rdata <= reg_rd ? next_rdata : 16'h0000;
		end
	end

endmodule : sdw_core

`default_nettype wire

// ### tb/sdw_props.sv
// Pin-level checker for the write-tail and self refresh sequencer.
// Assumes it is bound to sdw_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sdw_props #(
	parameter int TXS_CYC = 27
) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [2:0]  bank_addr,
	input wire logic [15:0] addr,
	input wire logic        wr_data_valid,
	input wire logic        dll_enable,
	input wire logic        dll_reset,
	input wire logic        self_refresh,
	input wire logic        refresh_pulse,
	input wire logic        exit_busy,
	input wire logic [7:0]  bank_open
);
	// ********
	// Decode
	// ********
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire logic       pre = cke && !self_refresh && cmd == sdw_pkg::CMD_PRE;
	logic [7:0]      busy_cnt;

	always_ff @(posedge core_clk) begin
		busy_cnt <= (rst || !exit_busy) ? 8'h00 : busy_cnt + 8'h01;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	a_sr_entry: assert property (!cke && cmd == sdw_pkg::CMD_REF &&
		!self_refresh && !exit_busy |=> self_refresh && !dll_enable)
		else $error("self refresh entry missed");
	a_exit_dll: assert property (self_refresh && cke |=>
		dll_reset && dll_enable) else $error("dll not restarted");
	a_busy_len: assert property ($fell(exit_busy) |->
		busy_cnt == 8'(TXS_CYC)) else $error("exit window length");
	a_first_ref: assert property ($rose(self_refresh) |->
		##[0:2] refresh_pulse) else $error("no refresh on entry");
	a_sr_frozen: assert property (self_refresh && !cke |=>
		$stable(bank_open) && !wr_data_valid) else $error("acted in sr");
	a_pre_all: assert property (pre && addr[10] |=>
		bank_open == 8'h00) else $error("all-bank precharge");
	a_pre_one: assert property (pre && !addr[10] |=> bank_open ==
		($past(bank_open) & ~(8'h01 << $past(bank_addr))))
		else $error("one-bank precharge");
	a_act_open: assert property (cke && !self_refresh &&
		cmd == sdw_pkg::CMD_ACT |=> bank_open[$past(bank_addr)])
		else $error("activate did not open");

	c_entry: cover property ($rose(self_refresh));
	c_exit: cover property ($fell(exit_busy));
	c_pre_all: cover property (pre && addr[10]);
endmodule : sdw_props

bind sdw_core sdw_props #(.TXS_CYC(TXS_CYC)) u_props (.core_clk, .rst,
	.cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr, .wr_data_valid,
	.dll_enable, .dll_reset, .self_refresh, .refresh_pulse, .exit_busy,
	.bank_open);
`default_nettype wire

// ### tb/sdw_ctl_model.sv
// Memory controller stand-in driving command pins and write data.
// Assumes the bench calls issue() from a single process.
`timescale 1ns/1ps
`default_nettype none
module sdw_ctl_model (
	// Clock
	input  wire logic   core_clk,
	// Command pins and data
	output logic        cke,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [2:0]  bank_addr,
	output logic [15:0] addr,
	output logic [7:0]  wr_data
);
	// ********
	// Driver
	// ********
	initial begin
		{cs_n, ras_n, cas_n, we_n} = sdw_pkg::CMD_NOP;
		cke = 1'b1;
		bank_addr = 3'h0;
		addr = 16'h0000;
		wr_data = 8'h00;
	end

	// Data moves every cycle so a stale beat cannot pass
	always @(posedge core_clk) wr_data <= wr_data + 8'h01;

	task automatic issue(input logic [3:0] c, input logic [2:0] ba,
		input logic [15:0] a, input logic ck);
		@(posedge core_clk);
		{cs_n, ras_n, cas_n, we_n} <= c;
		bank_addr <= ba;
		addr <= a;
		cke <= ck;
		@(posedge core_clk);
		{cs_n, ras_n, cas_n, we_n} <= sdw_pkg::CMD_NOP;
		bank_addr <= ~ba;
		addr <= ~a;
	endtask : issue
endmodule : sdw_ctl_model
`default_nettype wire

// ### tb/tb_top.sv
// Bench: registers, burst lengths, precharge and self refresh.
// Assumes sdw_core with shortened TREF, TXSDLL and TXS counts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        core_clk, rst, cke, cs_n, ras_n, cas_n, we_n;
	logic [2:0]  bank_addr;
	logic [15:0] addr, reg_wdata, reg_rdata;
	logic [7:0]  wr_data, wr_data_out, bank_open;
	logic        wr_data_valid, wr_burst_last, dll_enable, dll_reset;
	logic        self_refresh, refresh_pulse, exit_busy, reg_wr, reg_rd;
	logic [3:0]  reg_addr;
	int          mismatches, comparisons, cycles, n;

	sdw_core #(.TXS_CYC(4), .TXSDLL_CYC(16), .TREF_CYC(20)) dut (.*);
	sdw_ctl_model u_ctl (.*);

	// ********
	// Tasks
	// ********
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : reg_read
	// Additive 1 plus write CAS 5 gives a latency of 6
	task automatic burst(input logic [1:0] bl, input logic a12, input int b);
		reg_write(sdw_pkg::REG_CFG, {7'h00, 4'h5, 3'h1, bl});
		u_ctl.issue(sdw_pkg::CMD_WR, 3'h0, {3'h0, a12, 12'h000}, 1'b1);
		#1 n = 0;
		while (!wr_data_valid && n < 40) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk(16'(n), 16'h0006);
		for (n = 0; wr_data_valid && n < 9; n++) begin
			chk(wr_burst_last, 1'(n == b - 1));
			chk(wr_data_out, 8'(wr_data - 8'h01));
			@(posedge core_clk);
			#1;
		end
		chk(16'(n), 16'(b));
	endtask : burst
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		reg_read(sdw_pkg::REG_CFG, sdw_pkg::CFG_RESET);
		reg_write(4'hF, 16'hFFFF);
		reg_read(4'hF, 16'h0000);
		burst(sdw_pkg::BL_OTF, 1'b0, 2);
		burst(sdw_pkg::BL_FIXED4, 1'b1, 2);
		burst(sdw_pkg::BL_OTF, 1'b1, 4);
		burst(sdw_pkg::BL_FIXED8, 1'b0, 4);
		for (int b = 0; b < 8; b++) begin
			u_ctl.issue(sdw_pkg::CMD_ACT, 3'(b), 16'h0000, 1'b1);
		end
		reg_read(sdw_pkg::REG_BANKS, 16'h00FF);
		u_ctl.issue(sdw_pkg::CMD_PRE, 3'h3, 16'h0000, 1'b1);
		reg_read(sdw_pkg::REG_BANKS, 16'h00F7);
		u_ctl.issue(sdw_pkg::CMD_PRE, 3'h5, 16'h0400, 1'b1);
		reg_read(sdw_pkg::REG_BANKS, 16'h0000);
		u_ctl.issue(sdw_pkg::CMD_REF, 3'h0, 16'h0000, 1'b0);
		u_ctl.issue(sdw_pkg::CMD_ACT, 3'h2, 16'h0000, 1'b0);
		reg_read(sdw_pkg::REG_STATUS, 16'h0001);
		chk(bank_open, 8'h00);
		repeat (25) @(posedge core_clk);
		u_ctl.issue(sdw_pkg::CMD_NOP, 3'h0, 16'h0000, 1'b1);
		n = 0;
		repeat (8) begin
			#1 n += int'(exit_busy === 1'b1);
			@(posedge core_clk);
		end
		chk(16'(n), 16'h0004);
		chk(dll_enable, 1'b1);
		repeat (20) @(posedge core_clk);
		reg_read(sdw_pkg::REG_STATUS, 16'h0008);
		reg_read(sdw_pkg::REG_REFCNT, 16'h0002);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
